// File: core/fault_recorder.sv
// file: fault recorder top, pickup/trip watcher and record builder
`timescale 1ns/10ps
`default_nettype none
module fault_recorder
  import fault_rec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // protection modules
  input wire logic [NUM_MODS-1:0] mod_pickup,
  input wire logic [NUM_MODS-1:0] mod_trip,
  input wire logic [NUM_MODS*SPEC_W-1:0] mod_func_info,
  input wire logic [NUM_MODS*MEAS_W-1:0] meas_values,
  input wire logic auto_reclose,
  // configuration
  input wire logic record_mode,
  input wire logic [TIME_W-1:0] meas_delay_ticks,
  input wire logic [STAMP_W-1:0] date_time,
  input wire logic [SET_W-1:0] param_set,
  input wire logic adapt_in_use,
  input wire logic [SET_W-1:0] active_adaptive_set,
  input wire logic [31:0] settings_ver,
  // readout and display
  input wire logic [PTR_W-1:0] rd_age,
  input wire logic notice_ack,
  output var fault_record_t rd_record,
  output logic rd_settings_changed,
  output var fault_record_t safe_record,
  output logic [PTR_W-1:0] rec_count,
  output logic notice,
  output logic [PTR_W-1:0] notice_idx,
  output logic gen_pickup,
  output logic gen_trip
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_WAIT_MEAS} rec_state_t;

  // =============================================
  // reset release: two flops, assert async, release sync
  logic rst_s1_r, rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // =============================================
  // general signals and edges
  logic pick_any, trip_any, pick_d_r, trip_d_r;
  logic pick_rise, pick_fall, trip_rise;
  assign pick_any = |mod_pickup;
  assign trip_any = |mod_trip;
  assign pick_rise = pick_any & ~pick_d_r;
  assign pick_fall = ~pick_any & pick_d_r;
  assign trip_rise = trip_any & ~trip_d_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pick_d_r <= 1'b0;
      trip_d_r <= 1'b0;
      gen_pickup <= 1'b0;
      gen_trip <= 1'b0;
    end else begin
      pick_d_r <= pick_any;
      trip_d_r <= trip_any;
      gen_pickup <= pick_any;
      gen_trip <= trip_any;
    end
  end

  // lowest-numbered module wins when several assert together
  function automatic logic [MOD_W-1:0] first_set(input logic [NUM_MODS-1:0] v);
    logic [MOD_W-1:0] idx;
    idx = '0;
    for (int i = NUM_MODS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = MOD_W'(i);
      end
    end
    return idx;
  endfunction

  // =============================================
  // millisecond tick prescaler
  logic [13:0] pre_r;
  logic tick;
  assign tick = (pre_r == TICK_LAST);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= tick ? '0 : pre_r + 14'h0001;
    end
  end

  // =============================================
  // record state machine
  rec_state_t state_r;
  fault_record_t cur_r;
  logic [TIME_W-1:0] dur_r, delay_r;
  logic commit_r, meas_done_r;
  logic [FNUM_W-1:0] fault_no_r, grid_no_r;
  logic [PTR_W-1:0] newest_idx;
  logic [PTR_W-1:0] store_cnt;
  fault_record_t store_rd;

  // fault counters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_no_r <= '0;
      grid_no_r <= '0;
    end else if (pick_rise) begin
      fault_no_r <= fault_no_r + FNUM_ONE;
      if (!auto_reclose) begin
        grid_no_r <= grid_no_r + FNUM_ONE;
      end
    end
  end

  // duration timer saturates rather than wrapping
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dur_r <= '0;
    end else if (pick_rise) begin
      dur_r <= '0;
    end else if (tick && dur_r != TIME_MAX) begin
      dur_r <= dur_r + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      delay_r <= '0;
      commit_r <= 1'b0;
      meas_done_r <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (pick_rise) begin
            state_r <= ST_ACTIVE;
            meas_done_r <= 1'b0;
            cur_r <= '0;
            cur_r.stamp <= date_time;
            cur_r.param_set <= param_set;
            cur_r.adapt_used <= adapt_in_use;
            cur_r.adapt_set <= adapt_in_use ? active_adaptive_set : '0;
            cur_r.fault_no <= fault_no_r + FNUM_ONE;
            cur_r.grid_no <= auto_reclose ? grid_no_r : grid_no_r + FNUM_ONE;
            cur_r.first_pickup <= first_set(mod_pickup);
            cur_r.func_info <= mod_func_info[first_set(mod_pickup)*SPEC_W +: SPEC_W];
            cur_r.settings_ver <= settings_ver;
          end
        end
        ST_ACTIVE, ST_WAIT_MEAS: begin
          // first trip of this fault: a level test, so a trip rising with the pickup is kept
          if (trip_any && !cur_r.tripped) begin
            cur_r.tripped <= 1'b1;
            cur_r.first_trip <= first_set(mod_trip);
            cur_r.time_to_trip <= dur_r;
            cur_r.ttt_valid <= (first_set(mod_trip) == cur_r.first_pickup);
            if (meas_delay_ticks == '0) begin
              cur_r.meas <= meas_values[NUM_MEAS*MEAS_W-1:0];
              meas_done_r <= 1'b1;
            end else begin
              delay_r <= meas_delay_ticks;
              state_r <= ST_WAIT_MEAS;
            end
          end
          if (state_r == ST_WAIT_MEAS && tick) begin
            if (delay_r == 24'h000001) begin
              cur_r.meas <= meas_values[NUM_MEAS*MEAS_W-1:0];
              meas_done_r <= 1'b1;
              state_r <= ST_ACTIVE;
            end else begin
              delay_r <= delay_r - 24'h000001;
            end
          end
          // pickup fall ends the fault; a pending delayed capture is cut short
          if (pick_fall) begin
            cur_r.duration <= dur_r;
            if (state_r == ST_WAIT_MEAS && !meas_done_r) begin
              cur_r.meas <= meas_values[NUM_MEAS*MEAS_W-1:0];
            end
            commit_r <= cur_r.tripped || (record_mode == MODE_ALARMS_TRIPS);
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // =============================================
  // storage
  fault_rec_store u_store (
    .clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(commit_r),
    .wr_rec(cur_r),
    .rd_age(rd_age),
    .rd_rec(store_rd),
    .count(store_cnt),
    .newest_idx(newest_idx)
  );

  // power-safe copy of the newest record, registered outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      safe_record <= '0;
      rd_record <= '0;
      rd_settings_changed <= 1'b0;
      rec_count <= '0;
    end else begin
      if (commit_r) begin
        safe_record <= cur_r;
      end
      rd_record <= store_rd;
      rd_settings_changed <= (store_cnt != '0) && (store_rd.settings_ver != settings_ver);
      rec_count <= store_cnt;
    end
  end

  // display notice: a new commit wins over a simultaneous acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      notice <= 1'b0;
      notice_idx <= '0;
    end else if (commit_r) begin
      notice <= 1'b1;
      notice_idx <= (newest_idx == PTR_LAST) ? PTR_ZERO : newest_idx + 5'h01;
    end else if (notice_ack) begin
      notice <= 1'b0;
    end
  end

  // =============================================
  // checks
  property p_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_IDLE && pick_rise) |=> state_r == ST_ACTIVE;
  endproperty
  a_start: assert property (p_start) else $error("no record start on pickup");

  property p_gen;
    @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> (gen_pickup == |$past(mod_pickup)) && (gen_trip == |$past(mod_trip));
  endproperty
  a_gen: assert property (p_gen) else $error("general signal wrong");

  property p_notice;
    @(posedge sys_clk) disable iff (!rst_n)
      commit_r |=> notice;
  endproperty
  a_notice: assert property (p_notice) else $error("notice not raised");

  property p_trips_only;
    @(posedge sys_clk) disable iff (!rst_n)
      (pick_fall && state_r == ST_ACTIVE && !cur_r.tripped && record_mode == MODE_TRIPS_ONLY)
      |=> !commit_r;
  endproperty
  a_trips_only: assert property (p_trips_only) else $error("untripped record kept");

  property p_alarms;
    @(posedge sys_clk) disable iff (!rst_n)
      (pick_fall && state_r == ST_ACTIVE && record_mode == MODE_ALARMS_TRIPS) |=> commit_r;
  endproperty
  a_alarms: assert property (p_alarms) else $error("alarm record lost");

  property p_count;
    @(posedge sys_clk) disable iff (!rst_n)
      store_cnt <= CNT_FULL;
  endproperty
  a_count: assert property (p_count) else $error("store count above depth");

  property p_fno;
    @(posedge sys_clk) disable iff (!rst_n)
      pick_rise |=> fault_no_r == $past(fault_no_r) + FNUM_ONE;
  endproperty
  a_fno: assert property (p_fno) else $error("fault number not counted");

  property p_safe;
    @(posedge sys_clk) disable iff (!rst_n)
      commit_r |=> safe_record == $past(cur_r);
  endproperty
  a_safe: assert property (p_safe) else $error("safe copy not updated");

  property p_immediate;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_ACTIVE && trip_any && !cur_r.tripped && meas_delay_ticks == '0)
      |=> meas_done_r && cur_r.tripped;
  endproperty
  a_immediate: assert property (p_immediate) else $error("trip capture missed");

  // first trip of a fault fixes module, time and availability of time to trip
  property p_ttt;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r != ST_IDLE && trip_any && !cur_r.tripped) |=> cur_r.tripped
        && (cur_r.time_to_trip == $past(dur_r))
        && (cur_r.ttt_valid == (cur_r.first_trip == cur_r.first_pickup));
  endproperty
  a_ttt: assert property (p_ttt) else $error("time to trip wrong");

  property p_dur;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r != ST_IDLE && pick_fall)
      |=> state_r == ST_IDLE && cur_r.duration == $past(dur_r);
  endproperty
  a_dur: assert property (p_dur) else $error("fault duration wrong");

  // low measurement word, as the delayed capture must see it
  logic [NUM_MEAS*MEAS_W-1:0] meas_low;
  assign meas_low = meas_values[NUM_MEAS*MEAS_W-1:0];
  property p_delayed;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_WAIT_MEAS && tick && delay_r == 24'h000001 && !pick_fall)
      |=> meas_done_r && cur_r.meas == $past(meas_low);
  endproperty
  a_delayed: assert property (p_delayed) else $error("delayed capture missed");

  property p_grid;
    @(posedge sys_clk) disable iff (!rst_n)
      (pick_rise && auto_reclose) |=> grid_no_r == $past(grid_no_r);
  endproperty
  a_grid: assert property (p_grid) else $error("grid number counted in reclose");

  c_commit: cover property (@(posedge sys_clk) disable iff (!rst_n) commit_r);
  c_delay: cover property (@(posedge sys_clk) disable iff (!rst_n) state_r == ST_WAIT_MEAS);
  c_full: cover property (@(posedge sys_clk) disable iff (!rst_n) store_cnt == CNT_FULL);
  c_alarm_only: cover property (@(posedge sys_clk) disable iff (!rst_n) commit_r && !cur_r.tripped);
  c_late_trip: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_ACTIVE && trip_rise);
endmodule
`default_nettype wire

// File: core/fault_rec_pkg.sv
// package: shared constants and record layout for the fault recorder
package fault_rec_pkg;
  // ==========================================
  // sizes
  localparam int NUM_MODS = 8;
  localparam int MOD_W = 3;
  localparam int DEPTH = 20;
  localparam int PTR_W = 5;
  localparam int TIME_W = 24;
  localparam int MEAS_W = 16;
  localparam int NUM_MEAS = 4;
  localparam int FNUM_W = 16;
  localparam int STAMP_W = 32;
  localparam int SET_W = 2;
  localparam int SPEC_W = 8;
  // ==========================================
  // timing: one tick per millisecond at 10 MHz
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [13:0] TICK_LAST = 14'(TICK_CYC - 1);
  localparam logic [PTR_W-1:0] PTR_LAST = 5'h13;
  localparam logic [PTR_W-1:0] PTR_ZERO = 5'h00;
  localparam logic [PTR_W-1:0] CNT_FULL = 5'h14;
  localparam logic [TIME_W-1:0] TIME_MAX = 24'hFFFFFF;
  localparam logic [FNUM_W-1:0] FNUM_ONE = 16'h0001;
  // ==========================================
  typedef enum logic {MODE_TRIPS_ONLY, MODE_ALARMS_TRIPS} rec_mode_t;
  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [FNUM_W-1:0] fault_no;
    logic [FNUM_W-1:0] grid_no;
    logic [SET_W-1:0] param_set;
    logic adapt_used;
    logic [SET_W-1:0] adapt_set;
    logic [TIME_W-1:0] duration;
    logic [TIME_W-1:0] time_to_trip;
    logic ttt_valid;
    logic [MOD_W-1:0] first_pickup;
    logic [MOD_W-1:0] first_trip;
    logic tripped;
    logic [SPEC_W-1:0] func_info;
    logic [NUM_MEAS*MEAS_W-1:0] meas;
    logic [31:0] settings_ver;
  } fault_record_t;
endpackage

// File: core/fault_rec_store.sv
// file: twenty-entry ring store of committed fault records
`timescale 1ns/10ps
`default_nettype none
module fault_rec_store
  import fault_rec_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // commit side
  input wire logic wr_en,
  input var fault_record_t wr_rec,
  // read side
  input wire logic [PTR_W-1:0] rd_age,
  output var fault_record_t rd_rec,
  output logic [PTR_W-1:0] count,
  output logic [PTR_W-1:0] newest_idx
);
  fault_record_t mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] cnt_r;
  logic [PTR_W-1:0] rd_idx;

  // =============================================
  // whole record written in one cycle, so a reader never sees a half record
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_ptr_r] <= wr_rec;
    end
  end

  // ring pointer: when full the oldest slot is simply overwritten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= PTR_ZERO;
      cnt_r <= PTR_ZERO;
    end else if (wr_en) begin
      wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? PTR_ZERO : wr_ptr_r + 5'h01;
      if (cnt_r != CNT_FULL) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // age 0 is the newest record
  always_comb begin
    newest_idx = (wr_ptr_r == PTR_ZERO) ? PTR_LAST : wr_ptr_r - 5'h01;
    if (rd_age > newest_idx) begin
      rd_idx = 5'(newest_idx + CNT_FULL - rd_age);
    end else begin
      rd_idx = newest_idx - rd_age;
    end
  end

  assign rd_rec = mem[rd_idx];
  assign count = cnt_r;
endmodule
`default_nettype wire

// File: verification/prot_mods_model.sv
// model of the protection modules feeding the fault recorder
`timescale 1ns/10ps
`default_nettype none
module prot_mods_model
  import fault_rec_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire logic [NUM_MODS-1:0] pick_cmd,
  input wire logic [NUM_MODS-1:0] trip_cmd,
  input wire logic [NUM_MODS*MEAS_W-1:0] meas_cmd,
  // toward the recorder
  output logic [NUM_MODS-1:0] mod_pickup,
  output logic [NUM_MODS-1:0] mod_trip,
  output logic [NUM_MODS*SPEC_W-1:0] mod_func_info,
  output logic [NUM_MODS*MEAS_W-1:0] meas_values
);
  // each module reports its own index, so a wrong slice shows up
  always_comb begin
    for (int i = 0; i < NUM_MODS; i++) begin
      mod_func_info[i*SPEC_W +: SPEC_W] = 8'hA0 | 8'(i);
    end
  end
  // a module trips only while picked up, like a real function
  always_ff @(posedge sys_clk) begin
    mod_pickup <= pick_cmd;
    mod_trip <= trip_cmd & pick_cmd;
    meas_values <= meas_cmd;
  end
endmodule
`default_nettype wire

// File: verification/fault_recorder_tb_top.sv
// self-checking testbench for the fault recorder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module fault_recorder_tb_top
  import fault_rec_pkg::*;
  ;
  // ==========================================
  // stimulus and observed signals
  localparam logic [127:0] MEAS_A = 128'hDEAD_BEEF_DEAD_BEEF_1111_2222_3333_4444;
  localparam logic [127:0] MEAS_B = 128'hCAFE_F00D_CAFE_F00D_5555_6666_7777_8888;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [NUM_MODS-1:0] pick_cmd = '0;
  logic [NUM_MODS-1:0] trip_cmd = '0;
  logic [NUM_MODS*MEAS_W-1:0] meas_cmd = '0;
  logic auto_reclose = 1'b0;
  logic record_mode = 1'b0;
  logic [TIME_W-1:0] meas_delay_ticks = '0;
  logic [STAMP_W-1:0] date_time = 32'h1234_5678;
  logic [31:0] settings_ver = 32'h0000_0001;
  logic [SET_W-1:0] param_set = 2'h2;
  logic adapt_in_use = 1'b1;
  logic [SET_W-1:0] active_adaptive_set = 2'h3;
  logic [PTR_W-1:0] rd_age = '0;
  logic notice_ack = 1'b0;
  logic [NUM_MODS-1:0] mod_pickup;
  logic [NUM_MODS-1:0] mod_trip;
  logic [NUM_MODS*SPEC_W-1:0] mod_func_info;
  logic [NUM_MODS*MEAS_W-1:0] meas_values;
  fault_record_t rd_record;
  fault_record_t safe_record;
  logic rd_settings_changed;
  logic notice;
  logic gen_pickup;
  logic gen_trip;
  logic [PTR_W-1:0] rec_count;
  logic [PTR_W-1:0] notice_idx;
  int errors = 0;
  int tests_run = 0;
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  prot_mods_model prot_mods_model_inst (.sys_clk(sys_clk), .pick_cmd(pick_cmd),
    .trip_cmd(trip_cmd), .meas_cmd(meas_cmd), .mod_pickup(mod_pickup),
    .mod_trip(mod_trip), .mod_func_info(mod_func_info), .meas_values(meas_values));
  fault_recorder fault_recorder_inst (.sys_clk(sys_clk), .nrst(nrst),
    .mod_pickup(mod_pickup), .mod_trip(mod_trip), .mod_func_info(mod_func_info),
    .meas_values(meas_values), .auto_reclose(auto_reclose), .record_mode(record_mode),
    .meas_delay_ticks(meas_delay_ticks), .date_time(date_time), .param_set(param_set),
    .adapt_in_use(adapt_in_use), .active_adaptive_set(active_adaptive_set),
    .settings_ver(settings_ver),
    .rd_age(rd_age), .notice_ack(notice_ack), .rd_record(rd_record),
    .rd_settings_changed(rd_settings_changed), .safe_record(safe_record),
    .rec_count(rec_count), .notice(notice), .notice_idx(notice_idx),
    .gen_pickup(gen_pickup), .gen_trip(gen_trip));
  // ==========================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one whole fault; measurements change after the trip so capture time shows
  task automatic fault(input logic [7:0] pm, input logic [7:0] tm, input int tt, input int te);
    notice_ack <= 1'b1;
    @(posedge sys_clk);
    notice_ack <= 1'b0;
    meas_cmd <= MEAS_A;
    pick_cmd <= pm;
    repeat (tt) @(posedge sys_clk);
    trip_cmd <= tm;
    repeat (3) @(posedge sys_clk);
    `CHK("gen_pickup", 1'b1, gen_pickup)
    `CHK("gen_trip", |tm, gen_trip)
    repeat (10) @(posedge sys_clk);
    meas_cmd <= MEAS_B;
    repeat (te) @(posedge sys_clk);
    pick_cmd <= '0;
    trip_cmd <= '0;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic rec_chk(input int fno, input int gno, input logic trp, input int cnt);
    `CHK("fault_no", 16'(fno), rd_record.fault_no)
    `CHK("grid_no", 16'(gno), rd_record.grid_no)
    `CHK("tripped", trp, rd_record.tripped)
    `CHK("rec_count", 5'(cnt), rec_count)
    `CHK("notice", 1'b1, notice)
    `CHK("safe_record", rd_record, safe_record)
  endtask
  // ==========================================
  // test sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    fault(8'h04, 8'h04, TICK_CYC * 3 / 2, TICK_CYC);
    rec_chk(1, 1, 1'b1, 1);
    `CHK("ttt_valid", 1'b1, rd_record.ttt_valid)
    `CHK("time_to_trip", 24'h000001, rd_record.time_to_trip)
    `CHK("duration", 24'h000002, rd_record.duration)
    `CHK("first_pickup", 3'h2, rd_record.first_pickup)
    `CHK("first_trip", 3'h2, rd_record.first_trip)
    `CHK("func_info", 8'hA2, rd_record.func_info)
    `CHK("meas", MEAS_A[63:0], rd_record.meas)
    `CHK("stamp", 32'h1234_5678, rd_record.stamp)
    `CHK("param_set", 2'h2, rd_record.param_set)
    `CHK("adapt_set", 2'h3, rd_record.adapt_set)
    `CHK("notice_idx", 5'h00, notice_idx)
    `CHK("settings_changed", 1'b0, rd_settings_changed)
    notice_ack <= 1'b1;
    @(posedge sys_clk);
    notice_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK("notice", 1'b0, notice)
    $display("test trip_fault done");
    // alarm without trip is dropped in trips-only mode
    fault(8'h01, 8'h00, 5, 5);
    `CHK("rec_count", 5'h01, rec_count)
    `CHK("fault_no", 16'h0001, rd_record.fault_no)
    $display("test trips_only done");
    record_mode <= 1'b1;
    auto_reclose <= 1'b1;
    date_time <= 32'h0000_0ABC;
    param_set <= 2'h1;
    adapt_in_use <= 1'b0;
    fault(8'h48, 8'h00, 5, 5);
    rec_chk(3, 2, 1'b0, 2);
    `CHK("first_pickup", 3'h3, rd_record.first_pickup)
    `CHK("func_info", 8'hA3, rd_record.func_info)
    `CHK("stamp", 32'h0000_0ABC, rd_record.stamp)
    `CHK("param_set", 2'h1, rd_record.param_set)
    `CHK("adapt_used", 1'b0, rd_record.adapt_used)
    `CHK("adapt_set", 2'h0, rd_record.adapt_set)
    $display("test alarms_and_trips done");
    record_mode <= 1'b0;
    auto_reclose <= 1'b0;
    fault(8'h22, 8'h20, 5, 5);
    rec_chk(4, 3, 1'b1, 3);
    `CHK("first_pickup", 3'h1, rd_record.first_pickup)
    `CHK("first_trip", 3'h5, rd_record.first_trip)
    `CHK("ttt_valid", 1'b0, rd_record.ttt_valid)
    $display("test two_modules done");
    meas_delay_ticks <= 24'h000001;
    fault(8'h80, 8'h80, 5, 2 * TICK_CYC);
    rec_chk(5, 4, 1'b1, 4);
    `CHK("meas", MEAS_B[63:0], rd_record.meas)
    settings_ver <= 32'h0000_0002;
    repeat (3) @(posedge sys_clk);
    `CHK("settings_changed", 1'b1, rd_settings_changed)
    $display("test capture_delay done");
    // overfill the store so the two oldest records fall out
    meas_delay_ticks <= '0;
    for (int i = 0; i < 18; i++) begin
      fault(8'h01, 8'h01, 2, 2);
    end
    rec_chk(23, 22, 1'b1, 20);
    `CHK("notice_idx", 5'h01, notice_idx)
    rd_age <= 5'h13;
    repeat (3) @(posedge sys_clk);
    `CHK("oldest_fault_no", 16'h0004, rd_record.fault_no)
    $display("test store_wrap done");
    tally_and_finish();
  end
  // watchdog: the sequence needs about 46000 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
